// ==== design/sfcfe_params.svh ====
// Overview of operation
// - top-boot protect_level maps to none, top 4..64 KB, upper half, or all.
// - pause never aborts a status-write, program or wipe cycle under way.
// - pause starts only while selected, on pause_n falling with clock low.
// - pause ends on pause_n rising while the serial clock is low.
// - a pause_n edge with clock high takes effect when clock next goes low.
// - while paused, output floats; input and clock are ignored, state kept.
// - deselect during pause resets command logic and drops the sequence.
// - everything shifts MSB first; input captured on rising clock edges.
// - reads, status reads and wake-with-id return data until deselect.
// - write-type commands and sleep run only on whole-byte clock counts; wake and 3Ah do not need them.
// - incomplete page write byte means no operation, write_latch kept.
// - page write needs three address bytes and at least one data byte.
// - block wipe needs exactly 24 address bits, otherwise ignored.
// - wake command is ignored without its minimum byte count.
// - array commands are ignored while an internal cycle runs.
// - 03h reads with three address bytes, 0Bh adds one dummy byte.
// - 02h page write, D8h block wipe with address, C7h whole wipe.
// - 06h sets latch, 04h clears, 05h status read, 01h status write.
// - B9h sleep, ABh wake with three dummies then id, 3Ah one-time area.
// - 90h two dummies and selector then maker/device; 9Fh maker and 16-bit id.
// - works with clock idling low or high, modes 0 and 3.
// - each output bit is driven on the falling serial clock edge.
// - in sleep only the wake command is honoured.
`ifndef SFCFE_PARAMS_SVH
`define SFCFE_PARAMS_SVH

`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST_READ 8'h0B
`define SFCFE_OP_PAGE_WRITE 8'h02
`define SFCFE_OP_BLOCK_WIPE 8'hD8
`define SFCFE_OP_ARRAY_WIPE 8'hC7
`define SFCFE_OP_SET_LATCH 8'h06
`define SFCFE_OP_CLEAR_LATCH 8'h04
`define SFCFE_OP_STATUS_READ 8'h05
`define SFCFE_OP_STATUS_WRITE 8'h01
`define SFCFE_OP_SLEEP 8'hB9
`define SFCFE_OP_WAKE 8'hAB
`define SFCFE_OP_ONE_TIME 8'h3A
`define SFCFE_OP_MAKER_DEV 8'h90
`define SFCFE_OP_IDENT 8'h9F

// byte counts, opcode included
`define SFCFE_ADDR_LAST_IDX 3
`define SFCFE_SWR_BYTES 2
`define SFCFE_WIPE_BYTES 4
`define SFCFE_PAGE_MIN_BYTES 5
`define SFCFE_WAKE_MIN_BYTES 1

// status byte field positions
`define SFCFE_ST_LOCK 7
`define SFCFE_ST_LEVEL_HI 4
`define SFCFE_ST_LEVEL_LO 2

// top-boot protected range start per protect_level
`define SFCFE_PROT_BASE_1 24'h3FF000
`define SFCFE_PROT_BASE_2 24'h3FE000
`define SFCFE_PROT_BASE_3 24'h3FC000
`define SFCFE_PROT_BASE_4 24'h3F8000
`define SFCFE_PROT_BASE_5 24'h3F0000
`define SFCFE_PROT_BASE_6 24'h200000
`define SFCFE_PROT_BASE_7 24'h000000

// reset values
`define SFCFE_LEVEL_RST 3'h0
`define SFCFE_LOCK_RST 1'h0

`endif

// ==== design/sfcfe_pkg.sv ====
package sfcfe_pkg;
	typedef enum logic [0:0]
	{
		SFCFE_SHIFT_IN = 1'b0,
		SFCFE_SHIFT_OUT = 1'b1
	} sfcfe_phase_t;
	typedef logic [7:0] sfcfe_byte_t;
	typedef logic [23:0] sfcfe_addr_t;
	typedef logic [2:0] sfcfe_level_t;
endpackage

// ==== design/sfcfe_prot_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sfcfe_prot_if;
	import sfcfe_pkg::*;
	sfcfe_level_t protect_level;
	sfcfe_addr_t addr;
	logic is_protected;
	modport lookup (input protect_level, input addr, output is_protected);
	modport user (output protect_level, output addr, input is_protected);
endinterface
`default_nettype wire

// ==== design/sfcfe_protect_map.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_params.svh"
module sfcfe_protect_map
	import sfcfe_pkg::*;
(
	sfcfe_prot_if.lookup prot
);
	////////////////////////////////////////////////////////////////
	// lowest protected address per level
	function automatic sfcfe_addr_t base_of(input sfcfe_level_t lvl);
		case (lvl)
			3'h1: base_of = `SFCFE_PROT_BASE_1;
			3'h2: base_of = `SFCFE_PROT_BASE_2;
			3'h3: base_of = `SFCFE_PROT_BASE_3;
			3'h4: base_of = `SFCFE_PROT_BASE_4;
			3'h5: base_of = `SFCFE_PROT_BASE_5;
			3'h6: base_of = `SFCFE_PROT_BASE_6;
			default: base_of = `SFCFE_PROT_BASE_7;
		endcase
	endfunction

	// level zero guards nothing, others guard from base to the top
	assign prot.is_protected = (prot.protect_level != 3'h0) &&
		(prot.addr >= base_of(prot.protect_level));
endmodule
`default_nettype wire

// ==== design/sfcfe_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_params.svh"
module sfcfe_front_end
	import sfcfe_pkg::*;
#(
	parameter int CNT_W = 13,
	parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'hA5, // arbitrary value
	parameter logic [15:0] IDENT16 = 16'h1234 // arbitrary value
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic pause_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe_n,
	input wire logic cycle_busy,
	input wire logic [7:0] array_data,
	output logic [23:0] array_addr,
	output logic [23:0] command_addr,
	output logic page_byte_valid,
	output logic [7:0] page_byte,
	output logic [23:0] page_byte_addr,
	output logic page_write_start,
	output logic block_wipe_start,
	output logic array_wipe_start,
	output logic status_write_start,
	output logic write_latch,
	output logic [2:0] protect_level,
	output logic status_lock,
	output logic one_time_mode,
	output logic sleeping,
	output logic paused
);
	localparam int IW = CNT_W - 3;

	////////////////////////////////////////////////////////////////
	// pin synchronisers, third stage only for edge finding
	logic sclk_m, sclk_s, sclk_d;
	logic sel_m, sel_s, sel_d;
	logic pause_m, pause_s;
	logic si_m, si_s;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			{sclk_m, sclk_s, sclk_d} <= 3'h0;
			{sel_m, sel_s, sel_d} <= 3'h7;
			{pause_m, pause_s} <= 2'h3;
			{si_m, si_s} <= 2'h0;
		end
		else
		begin
			{sclk_m, sclk_s, sclk_d} <= {sclk, sclk_m, sclk_s};
			{sel_m, sel_s, sel_d} <= {select_n, sel_m, sel_s};
			{pause_m, pause_s} <= {pause_n, pause_m};
			{si_m, si_s} <= {serial_in, si_m};
		end
	end

	logic sclk_rise, sclk_fall, sel_rise, active, shift_rise, shift_fall;
	// only edges count, so either idle level of the clock works
	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;
	assign sel_rise = sel_s & ~sel_d;
	assign active = ~sel_s & ~paused;
	assign shift_rise = sclk_rise & active;
	assign shift_fall = sclk_fall & active;

	////////////////////////////////////////////////////////////////
	// pause follows pause_n only while selected and clock is low
	always_ff @(posedge clk)
	begin
		if (reset)
			paused <= 1'b0;
		else if (sel_s)
			paused <= 1'b0;
		else if (!sclk_s)
			paused <= ~pause_s;
	end

	////////////////////////////////////////////////////////////////
	// clock count and input shifter
	logic [CNT_W-1:0] bit_count;
	logic [7:0] in_shift;
	logic [IW-1:0] cur_idx;
	logic byte_done;
	sfcfe_byte_t in_byte, opcode, op_now, sw_data;
	assign cur_idx = bit_count[CNT_W-1:3];
	assign byte_done = shift_rise & (bit_count[2:0] == 3'h7);
	assign in_byte = {in_shift[6:0], si_s};
	assign op_now = (cur_idx == IW'(0)) ? in_byte : opcode;

	always_ff @(posedge clk)
	begin
		if (reset || sel_s)
			bit_count <= '0;
		else if (shift_rise && (bit_count != '1))
			bit_count <= bit_count + 1'b1;
	end

	// msb first, captured on rising edges
	always_ff @(posedge clk)
	begin
		if (reset)
			in_shift <= 8'h00;
		else if (shift_rise)
			in_shift <= in_byte;
	end

	// opcode and status-write data byte
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			opcode <= 8'h00;
			sw_data <= 8'h00;
		end
		else if (byte_done && (cur_idx == IW'(0)))
			opcode <= in_byte;
		else if (byte_done && (cur_idx == IW'(1)))
			sw_data <= in_byte;
	end

	////////////////////////////////////////////////////////////////
	// command qualification
	function automatic logic [2:0] out_start(input sfcfe_byte_t op);
		case (op)
			`SFCFE_OP_STATUS_READ, `SFCFE_OP_IDENT: out_start = 3'h1;
			`SFCFE_OP_READ, `SFCFE_OP_MAKER_DEV, `SFCFE_OP_WAKE: out_start = 3'h4;
			`SFCFE_OP_FAST_READ: out_start = 3'h5;
			default: out_start = 3'h0;
		endcase
	endfunction

	function automatic logic is_array_op(input sfcfe_byte_t op);
		is_array_op = (op == `SFCFE_OP_READ) || (op == `SFCFE_OP_FAST_READ) ||
			(op == `SFCFE_OP_PAGE_WRITE) || (op == `SFCFE_OP_BLOCK_WIPE) ||
			(op == `SFCFE_OP_ARRAY_WIPE) || (op == `SFCFE_OP_STATUS_WRITE);
	endfunction

	// sleep admits only wake; a running cycle blocks array access
	function automatic logic allowed(input sfcfe_byte_t op, input logic slp, input logic bsy);
		allowed = !(slp && (op != `SFCFE_OP_WAKE)) && !(bsy && is_array_op(op));
	endfunction

	////////////////////////////////////////////////////////////////
	// address: captured, bumped per read byte or per page byte
	sfcfe_addr_t addr, start_addr;
	sfcfe_phase_t phase;
	logic [2:0] out_bit;
	logic [1:0] out_sel;
	logic drive, alt_first;
	logic out_wrap;
	assign out_wrap = shift_fall && (phase == SFCFE_SHIFT_OUT) && (out_bit == 3'h7);

	always_ff @(posedge clk)
	begin
		if (reset)
			addr <= 24'h000000;
		else if (byte_done && (cur_idx >= IW'(1)) && (cur_idx <= IW'(`SFCFE_ADDR_LAST_IDX)))
			addr <= {addr[15:0], in_byte};
		else if (byte_done && (cur_idx > IW'(`SFCFE_ADDR_LAST_IDX)) && (opcode == `SFCFE_OP_PAGE_WRITE))
			addr[7:0] <= addr[7:0] + 8'h01; // stays inside the page
		else if (out_wrap && ((opcode == `SFCFE_OP_READ) || (opcode == `SFCFE_OP_FAST_READ)))
			addr <= addr + 24'h000001;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			start_addr <= 24'h000000;
		else if (byte_done && (cur_idx == IW'(`SFCFE_ADDR_LAST_IDX)))
			start_addr <= {addr[15:0], in_byte};
	end

	// selector byte of the maker/device read picks the first byte
	always_ff @(posedge clk)
	begin
		if (reset)
			alt_first <= 1'b0;
		else if (byte_done && (cur_idx == IW'(`SFCFE_ADDR_LAST_IDX)))
			alt_first <= in_byte[0];
	end

	////////////////////////////////////////////////////////////////
	// frame phase: input shifting, then output after the header
	always_ff @(posedge clk)
	begin
		if (reset || sel_s)
			phase <= SFCFE_SHIFT_IN;
		else
		begin
			case (phase)
				SFCFE_SHIFT_IN:
					if (byte_done && (out_start(op_now) != 3'h0) &&
						(cur_idx == IW'(out_start(op_now) - 3'h1)) &&
						allowed(op_now, sleeping, cycle_busy))
						phase <= SFCFE_SHIFT_OUT;
				SFCFE_SHIFT_OUT:
					phase <= SFCFE_SHIFT_OUT;
				default:
					phase <= SFCFE_SHIFT_IN;
			endcase
		end
	end

	// output byte source
	sfcfe_byte_t status_byte, out_src;
	logic [7:0] out_shift;
	assign status_byte = {status_lock, 2'b00, protect_level, write_latch, cycle_busy};

	always_comb
	begin
		case (opcode)
			`SFCFE_OP_STATUS_READ: out_src = status_byte;
			`SFCFE_OP_READ, `SFCFE_OP_FAST_READ: out_src = array_data;
			`SFCFE_OP_IDENT: out_src = (out_sel == 2'h0) ? MAKER_ID :
				(out_sel == 2'h1) ? IDENT16[15:8] : IDENT16[7:0];
			`SFCFE_OP_MAKER_DEV: out_src = (out_sel[0] ^ alt_first) ? DEVICE_ID : MAKER_ID;
			default: out_src = DEVICE_ID;
		endcase
	end

	// output bits move on falling edges, msb first
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			serial_out <= 1'b0;
			out_shift <= 8'h00;
		end
		else if (shift_fall && (phase == SFCFE_SHIFT_OUT))
		begin
			if (out_bit == 3'h0)
			begin
				serial_out <= out_src[7];
				out_shift <= {out_src[6:0], 1'b0};
			end
			else
			begin
				serial_out <= out_shift[7];
				out_shift <= {out_shift[6:0], 1'b0};
			end
		end
	end

	// bit and byte counters of the output stream, reset by deselect
	always_ff @(posedge clk)
	begin
		if (reset || sel_s || (phase == SFCFE_SHIFT_IN))
		begin
			out_bit <= 3'h0;
			out_sel <= 2'h0;
			drive <= 1'b0;
		end
		else if (shift_fall)
		begin
			out_bit <= out_bit + 3'h1;
			drive <= 1'b1;
			if (out_wrap)
				out_sel <= ((opcode == `SFCFE_OP_IDENT) && (out_sel == 2'h2)) ?
					2'h0 : out_sel + 2'h1;
		end
	end

	// floats when not selected, paused or not yet sending
	assign serial_out_oe_n = ~(drive & active);

	////////////////////////////////////////////////////////////////
	// execution at deselect; a paused deselect executes nothing
	logic exec_ok, end_ok;
	logic [IW-1:0] nbytes;
	logic do_setl, do_clrl, do_swr, do_page, do_wipe, do_chip, do_sleep, do_wake, do_otp;
	sfcfe_prot_if prot ();
	assign end_ok = sel_rise & ~paused;
	assign exec_ok = end_ok & (bit_count[2:0] == 3'h0);
	assign nbytes = cur_idx;
	assign do_setl = exec_ok && !sleeping && (opcode == `SFCFE_OP_SET_LATCH) && (nbytes != 0);
	assign do_clrl = exec_ok && !sleeping && (opcode == `SFCFE_OP_CLEAR_LATCH) && (nbytes != 0);
	assign do_swr = exec_ok && allowed(opcode, sleeping, cycle_busy) && write_latch &&
		(opcode == `SFCFE_OP_STATUS_WRITE) && (nbytes >= IW'(`SFCFE_SWR_BYTES));
	assign do_page = exec_ok && allowed(opcode, sleeping, cycle_busy) && write_latch &&
		(opcode == `SFCFE_OP_PAGE_WRITE) && (nbytes >= IW'(`SFCFE_PAGE_MIN_BYTES)) &&
		!prot.is_protected;
	assign do_wipe = exec_ok && allowed(opcode, sleeping, cycle_busy) && write_latch &&
		(opcode == `SFCFE_OP_BLOCK_WIPE) && (nbytes == IW'(`SFCFE_WIPE_BYTES)) &&
		!prot.is_protected;
	assign do_chip = exec_ok && allowed(opcode, sleeping, cycle_busy) && write_latch &&
		(opcode == `SFCFE_OP_ARRAY_WIPE) && (nbytes == IW'(1)) && (protect_level == 3'h0);
	assign do_sleep = exec_ok && !sleeping && (opcode == `SFCFE_OP_SLEEP) && (nbytes != 0);
	assign do_wake = end_ok && sleeping && (opcode == `SFCFE_OP_WAKE) &&
		(nbytes >= IW'(`SFCFE_WAKE_MIN_BYTES));
	assign do_otp = end_ok && !sleeping && (opcode == `SFCFE_OP_ONE_TIME) && (nbytes != 0);

	assign prot.protect_level = protect_level;
	assign prot.addr = start_addr;

	sfcfe_protect_map u_map
	(
		.prot(prot)
	);

	// write latch: set by command, cleared by clear and by accepted writes
	always_ff @(posedge clk)
	begin
		if (reset)
			write_latch <= 1'b0;
		else if (do_setl)
			write_latch <= 1'b1;
		else if (do_clrl || do_swr || do_page || do_wipe || do_chip)
			write_latch <= 1'b0;
	end

	// status fields; in one-time mode the write only sets the lock
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			protect_level <= `SFCFE_LEVEL_RST;
			status_lock <= `SFCFE_LOCK_RST;
		end
		else if (do_swr && one_time_mode)
			status_lock <= 1'b1;
		else if (do_swr)
		begin
			protect_level <= sw_data[`SFCFE_ST_LEVEL_HI:`SFCFE_ST_LEVEL_LO];
			status_lock <= sw_data[`SFCFE_ST_LOCK];
		end
	end

	// sleep and one-time modes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sleeping <= 1'b0;
			one_time_mode <= 1'b0;
		end
		else
		begin
			if (do_sleep)
				sleeping <= 1'b1;
			else if (do_wake)
				sleeping <= 1'b0;
			if (do_otp)
				one_time_mode <= 1'b1;
			else if (do_clrl)
				one_time_mode <= 1'b0;
		end
	end

	// start pulses; nothing here ever cancels a running cycle
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			{page_write_start, block_wipe_start, array_wipe_start, status_write_start} <= 4'h0;
			command_addr <= 24'h000000;
		end
		else
		begin
			{page_write_start, block_wipe_start, array_wipe_start, status_write_start} <=
				{do_page, do_wipe, do_chip, do_swr};
			command_addr <= start_addr;
		end
	end

	// page data bytes as they complete
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			page_byte_valid <= 1'b0;
			page_byte <= 8'h00;
			page_byte_addr <= 24'h000000;
		end
		else
		begin
			page_byte_valid <= byte_done && (cur_idx > IW'(`SFCFE_ADDR_LAST_IDX)) &&
				(opcode == `SFCFE_OP_PAGE_WRITE) && write_latch &&
				allowed(opcode, sleeping, cycle_busy);
			page_byte <= in_byte;
			page_byte_addr <= addr;
		end
	end

	assign array_addr = addr;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_pause_cond;
		!sel_s && !sclk_s && !pause_s;
	endsequence

	sequence s_resume_cond;
		!sel_s && !sclk_s && pause_s;
	endsequence

	a_pause_floats: assert property (paused |-> serial_out_oe_n)
		else $error("output driven while paused");
	a_pause_frozen: assert property (paused && $past(paused) |-> $stable(bit_count) && $stable(in_shift))
		else $error("shift state moved while paused");
	a_pause_entry: assert property ($rose(paused) |-> $past(sclk_s == 1'b0 && sel_s == 1'b0 && pause_s == 1'b0))
		else $error("pause entered with clock high or deselected");
	a_pause_exit: assert property (s_pause_cond ##1 s_resume_cond |=> !paused)
		else $error("pause did not end on release with clock low");
	a_paused_discard: assert property (sel_rise && paused |=> !page_write_start && !block_wipe_start && !array_wipe_start && !status_write_start && $stable(write_latch))
		else $error("command executed after paused deselect");
	a_align_reject: assert property (sel_rise && (bit_count[2:0] != 3'h0) |=> !page_write_start && !block_wipe_start && !status_write_start && $stable(write_latch))
		else $error("misaligned command executed");
	a_busy_ignores: assert property (sel_rise && cycle_busy |=> !page_write_start && !block_wipe_start && !array_wipe_start && !status_write_start)
		else $error("array command accepted while busy");
	a_wipe_length: assert property (block_wipe_start |-> $past(nbytes == IW'(`SFCFE_WIPE_BYTES) && opcode == `SFCFE_OP_BLOCK_WIPE))
		else $error("block wipe with wrong length");
	a_page_min: assert property (page_write_start |-> $past(nbytes >= IW'(`SFCFE_PAGE_MIN_BYTES)))
		else $error("page write too short");
	a_sleep_gate: assert property (sleeping && sel_rise && opcode != `SFCFE_OP_WAKE |=> $stable(write_latch) && sleeping)
		else $error("command honoured in sleep");
	a_fall_drive: assert property ($changed(serial_out) |-> $past(sclk_fall))
		else $error("output changed off a falling edge");
endmodule
`default_nettype wire

// ==== tb/sfcfe_host.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// spi host model: 80 ns serial clock, still outside frames
module sfcfe_host
(
	output logic sclk,
	output logic select_n,
	output logic pause_n,
	output logic serial_in,
	input wire logic serial_out
);
	logic idle_hi;
	// idle link at time zero
	initial
	begin
		idle_hi = 1'b0;
		sclk = 1'b0;
		select_n = 1'b1;
		pause_n = 1'b1;
		serial_in = 1'b0;
	end
	// pause released before selecting again
	task automatic start(input logic mode3);
		pause_n = 1'b1;
		idle_hi = mode3;
		sclk = mode3;
		#40 select_n = 1'b0;
		#40;
	endtask
	// msb first, output sampled just before each rising edge
	task automatic bits(input logic [63:0] tx, input int n, output logic [63:0] rx);
		rx = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk = 1'b0;
			serial_in = tx[i];
			#40 rx = {rx[62:0], serial_out};
			sclk = 1'b1;
			#40;
		end
	endtask
	// deselect after the last bit; data line then goes stale
	task automatic stop();
		sclk = idle_hi;
		#40 select_n = 1'b1;
		serial_in = ~serial_in;
		#80;
	endtask
	// whole frame in one call
	task automatic frame(input logic mode3, input logic [63:0] tx, input int n,
		output logic [63:0] rx);
		start(mode3);
		bits(tx, n, rx);
		stop();
	endtask
	// direct pin control for pause sequences
	task automatic drive(input logic p, input logic c, input logic d);
		pause_n = p;
		sclk = c;
		serial_in = d;
	endtask
endmodule
`default_nettype wire

// ==== tb/test_serial_flash_command_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_command_front_end;
	import sfcfe_pkg::*;
	localparam logic [7:0] MAKER = 8'hC3; // arbitrary value
	localparam logic [7:0] DEVICE = 8'h3C; // arbitrary value
	localparam logic [15:0] IDENT = 16'hBEEF; // arbitrary value
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cycle_busy = 1'b0;
	logic [7:0] array_data = 8'h00;
	logic sclk, select_n, pause_n, serial_in, serial_out, serial_out_oe_n;
	logic [23:0] array_addr, command_addr, page_byte_addr;
	logic [7:0] page_byte;
	logic [2:0] protect_level;
	logic page_byte_valid, page_write_start, block_wipe_start, array_wipe_start;
	logic status_write_start, write_latch, status_lock, one_time_mode, sleeping, paused;
	logic [63:0] rx;
	logic [31:0] notes[$];
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	sfcfe_addr_t a;
	sfcfe_byte_t d0, d1;
	sfcfe_addr_t base[8] = '{24'h3FFFFF, 24'h3FF000, 24'h3FE000, 24'h3FC000,
		24'h3F8000, 24'h3F0000, 24'h200000, 24'h000000};

	sfcfe_front_end #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE), .IDENT16(IDENT)) DUT
	(
		.clk, .reset, .sclk, .select_n, .pause_n, .serial_in, .serial_out,
		.serial_out_oe_n, .cycle_busy, .array_data, .array_addr, .command_addr,
		.page_byte_valid, .page_byte, .page_byte_addr, .page_write_start,
		.block_wipe_start, .array_wipe_start, .status_write_start, .write_latch,
		.protect_level, .status_lock, .one_time_mode, .sleeping, .paused
	);
	// a released data line reads back inverted at the host
	logic host_line;
	assign host_line = serial_out_oe_n ? ~serial_out : serial_out;
	sfcfe_host host (.sclk, .select_n, .pause_n, .serial_in, .serial_out(host_line));

	////////////////////////////////////////////////////////////////
	// clock, timeout and array contents
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			bad_count++;
			final_report();
		end
	end
	function automatic sfcfe_byte_t fdat(input sfcfe_addr_t x);
		return x[7:0] ^ x[15:8] ^ 8'h5C;
	endfunction
	always @(negedge clk) array_data <= fdat(array_addr);

	////////////////////////////////////////////////////////////////
	// compare, note and report helpers
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic take(input string what, input logic [31:0] got);
		if (notes.size() == 0)
		begin
			check_count++;
			bad_count++;
			$display("MISMATCH %s expected none seen %h", what, got);
		end
		else
			check(what, notes.pop_front(), got);
	endtask
	task automatic fr(input logic [63:0] tx, input int n);
		host.frame(1'b0, tx, n, rx);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watcher: each pulse takes the oldest note
	always @(negedge clk)
		if (reset === 1'b0)
		begin
			if (page_byte_valid === 1'b1) take("page_byte", {page_byte_addr, page_byte});
			if (page_write_start === 1'b1) take("page_start", {8'h01, command_addr});
			if (block_wipe_start === 1'b1) take("wipe_start", {8'h02, command_addr});
			if (array_wipe_start === 1'b1) take("array_wipe", 32'h03000000);
			if (status_write_start === 1'b1) take("status_write", 32'h04000000);
		end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		void'($urandom(32'h353c));
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		check("reset_state", 32'h1, {write_latch, protect_level, status_lock, sleeping,
			paused, one_time_mode, serial_out_oe_n});
		// latch commands, whole bytes only
		fr(9'h00D, 9);
		check("write_latch", 32'h0, write_latch);
		fr(8'h06, 8);
		check("write_latch", 32'h1, write_latch);
		fr(16'h0500, 16);
		check("status", 32'h02, rx[7:0]);
		host.frame(1'b1, 16'h0500, 16, rx);
		check("status_mode3", 32'h02, rx[7:0]);
		fr(8'h04, 7);
		check("write_latch", 32'h1, write_latch);
		// page write with low address byte wrapping
		a = {2'b00, 14'($urandom()), 8'hFF};
		d0 = 8'($urandom());
		d1 = 8'($urandom());
		fr(8'h06, 8);
		notes.push_back({a, d0});
		notes.push_back({a[23:8], 8'h00, d1});
		notes.push_back({8'h01, a});
		fr({8'h02, a, d0, d1}, 48);
		check("write_latch", 32'h0, write_latch);
		fr(8'h06, 8);
		notes.push_back({a, d0});
		fr({8'h02, a, d0, 3'b101}, 43);
		check("write_latch", 32'h1, write_latch);
		fr({8'h02, a}, 32);
		check("write_latch", 32'h1, write_latch);
		// block wipe length, then whole wipe
		fr({8'hD8, a, 8'h00}, 40);
		fr({8'hD8, a[23:1]}, 31);
		notes.push_back({8'h02, a});
		fr({8'hD8, a}, 32);
		fr(8'h06, 8);
		notes.push_back(32'h03000000);
		fr(8'hC7, 8);
		// busy cycle refuses array commands
		@(negedge clk) cycle_busy = 1'b1;
		fr(8'h06, 8);
		fr({8'hD8, a}, 32);
		fr({8'h02, a, d0}, 40);
		fr(16'h0104, 16);
		fr(16'h0500, 16);
		check("status_busy", 32'h03, rx[7:0]);
		// random busy level must show in the status byte
		d1 = 8'($urandom());
		@(negedge clk) cycle_busy = d1[0];
		fr(16'h0500, 16);
		check("status_busy", {7'h01, d1[0]}, rx[7:0]);
		@(negedge clk) cycle_busy = 1'b0;
		// every protect level against its range start
		for (int l = 0; l < 8; l++)
		begin
			fr(8'h06, 8);
			notes.push_back(32'h04000000);
			fr({8'h01, 3'b000, 3'(l), 2'b00}, 16);
			fr(16'h0500, 16);
			check("status_level", {27'h0, 3'(l), 2'b00}, rx[7:0]);
			fr(8'h06, 8);
			if (l == 0) notes.push_back({8'h02, base[l]});
			fr({8'hD8, base[l]}, 32);
			if (l != 0 && l != 7) notes.push_back({8'h02, base[l] - 24'h1});
			if (l != 0 && l != 7) fr({8'hD8, base[l] - 24'h1}, 32);
		end
		fr(8'h06, 8);
		fr(8'hC7, 8);
		notes.push_back(32'h04000000);
		fr(16'h0100, 16);
		// reads and identification
		a = {2'b00, 14'($urandom()), 8'h7F};
		fr({8'h03, a, 16'h0}, 48);
		check("read", {fdat(a), fdat(a + 24'h1)}, rx[15:0]);
		host.frame(1'b1, {8'h0B, a, 24'h0}, 56, rx);
		check("fast_read", {fdat(a), fdat(a + 24'h1)}, rx[15:0]);
		fr({8'h9F, 24'h0}, 32);
		check("ident", {MAKER, IDENT}, rx[23:0]);
		fr({8'h90, 40'h0}, 48);
		check("maker_dev", {MAKER, DEVICE}, rx[15:0]);
		fr({8'h90, 24'h000001, 16'h0}, 48);
		check("maker_dev_alt", {DEVICE, MAKER}, rx[15:0]);
		// sleep and wake
		fr(8'hB9, 7);
		check("sleeping", 32'h0, sleeping);
		fr(8'hB9, 8);
		fr(8'h06, 8);
		check("sleep_latch", 32'h2, {sleeping, write_latch});
		fr({8'hAB, 32'h0}, 40);
		check("wake_id", {1'b0, DEVICE}, {sleeping, rx[7:0]});
		fr(8'h3A, 8);
		check("one_time", 32'h1, one_time_mode);
		// status write in one-time mode only sets the lock bit
		fr(8'h06, 8);
		notes.push_back(32'h04000000);
		fr(16'h0110, 16);
		fr(16'h0500, 16);
		check("one_time_lock", 32'h80, rx[7:0]);
		fr(8'h04, 8);
		check("one_time", 32'h0, one_time_mode);
		// pause inside a latch frame, pause_n dropped with clock high, entered once clock is low
		host.start(1'b0);
		host.bits(64'h0, 4, rx);
		host.drive(1'b0, 1'b1, 1'b0);
		#200 check("paused", 32'h0, paused);
		host.drive(1'b0, 1'b0, 1'b0);
		#200 check("paused_oe", 32'h3, {paused, serial_out_oe_n});
		repeat (3)
		begin
			host.drive(1'b0, 1'b1, 1'($urandom()));
			#40 host.drive(1'b0, 1'b0, 1'($urandom()));
			#40;
		end
		host.drive(1'b1, 1'b0, 1'b0);
		#200 check("paused", 32'h0, paused);
		host.bits(64'h6, 4, rx);
		host.stop();
		check("write_latch", 32'h1, write_latch);
		// deselect while paused drops the frame
		fr(8'h04, 8);
		host.start(1'b0);
		host.bits(64'h0, 4, rx);
		host.drive(1'b0, 1'b0, 1'b0);
		#200 check("paused", 32'h1, paused);
		host.stop();
		check("paused", 32'h0, paused);
		fr(8'h06, 8);
		check("write_latch", 32'h1, write_latch);
		repeat (20) @(negedge clk);
		check("pending_notes", 32'h0, notes.size());
		final_report();
	end
endmodule
`default_nettype wire
